// ### rtl/csp_clock_unit.sv
// Purpose: System clock unit control: oscillators, multiplier, mux, prescalers
// Assumes: Oscillator stability and failure come in as synchronous levels
// Notes: Derived clocks are one-cycle enables of core_clk
`timescale 1ns/1ps
module csp_clock_unit (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext_ref_tick,
    input  wire logic        external_crystal_oscillator_stable,
    input  wire logic        ext_osc_fail,
    input  wire logic        rc2m_ready_in,
    input  wire logic        r32m_ready_in,
    input  wire logic        rc32k_ready_in,
    output logic             ext_osc_enable,
    output logic [3:0]       ext_osc_type_select,
    output logic             watch_crystal_low_power,
    output logic             multiplier_enable,
    output logic [1:0]       multiplier_input_select,
    output logic [4:0]       multiplier_factor,
    output logic [2:0]       sys_clk_select,
    output logic             cpu_clk_en,
    output logic             per2x_clk_en,
    output logic             per4x_clk_en,
    output logic             irq_mask,
    output logic             nmi_pulse
);
    logic [3:0]  reg_idx;
    logic        wr_go;
    logic        rd_go;
    logic        wr_lo;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        xen_ff;
    csp_pkg::csp_xcfg_t xcfg_ff;
    csp_pkg::csp_mcfg_t mcfg_ff;
    logic        men_ff;
    logic [2:0]  sel_ff;
    csp_pkg::csp_psc_t psc_ff;
    logic        lock_ff;
    logic        fden_ff;
    logic [2:0]  prot_ff;
    csp_pkg::csp_xstate_t xst_ff;
    logic [15:0] xcnt_ff;
    logic        xrdy_ff;
    logic [7:0]  mcnt_ff;
    logic        mrdy_ff;
    logic        fail_ff;
    logic        fail_rise;
    logic [10:0] pa_cnt_ff;
    logic        pa_tick;
    logic [1:0]  pc_cnt_ff;
    logic        per4x_ff;
    logic        per2x_ff;
    logic        cpu_ff;
    logic        nmi_ff;
    logic        prot_open;
    logic        sel_ok;

    // Start-up delay per oscillator type
    function automatic logic [15:0] external_crystal_oscillator_delay(input logic [3:0] t);
        if (t == csp_pkg::XSEL_EXTCLK)
            return csp_pkg::XDLY_EXTCLK;
        else if (t == csp_pkg::XSEL_WATCH)
            return csp_pkg::XDLY_WATCH;
        else
            return csp_pkg::XDLY_XTAL;
    endfunction

    function automatic logic src_ready(input logic [2:0] s, input logic xr, input logic mr,
                                       input logic r2, input logic r32, input logic r32k);
        case (s)
            csp_pkg::SEL_RC2M:  return r2;
            csp_pkg::SEL_R32M:  return r32;
            csp_pkg::SEL_RC32K: return r32k;
            csp_pkg::SEL_EXTERNAL_CRYSTAL_OSCILLATOR:  return xr;
            csp_pkg::SEL_PLL:   return mr;
            default:            return 1'b0;
        endcase
    endfunction

    assign reg_idx   = avs_address[5:2];
    // Writes land at the accepting edge, when waitrequest is low
    assign wr_go     = avs_write && ack_ff;
    assign rd_go     = avs_read && !ack_ff;
    assign wr_lo     = wr_go && avs_byteenable[0];
    assign prot_open = (prot_ff != 3'h0);
    assign fail_rise = ext_osc_fail && !fail_ff && fden_ff;
    assign sel_ok    = src_ready(avs_writedata[2:0], xrdy_ff, mrdy_ff,
                                 rc2m_ready_in, r32m_ready_in, rc32k_ready_in);

    // One wait cycle, then acknowledge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 32'h0;
        end else if (rd_go) begin
            case (reg_idx)
                csp_pkg::OFS_OSC_EN:   rdata_ff <= {30'h0, men_ff, xen_ff};
                csp_pkg::OFS_OSC_RDY:  rdata_ff <= {30'h0, mrdy_ff, xrdy_ff};
                csp_pkg::OFS_EXTERNAL_CRYSTAL_OSCILLATOR_CFG: rdata_ff <= {27'h0, xcfg_ff};
                csp_pkg::OFS_MUL_CFG:  rdata_ff <= {25'h0, mcfg_ff};
                csp_pkg::OFS_CLK_SEL:  rdata_ff <= {29'h0, sel_ff};
                csp_pkg::OFS_PSC:      rdata_ff <= {26'h0, psc_ff};
                csp_pkg::OFS_LOCK:     rdata_ff <= {31'h0, lock_ff};
                csp_pkg::OFS_PROT:     rdata_ff <= {31'h0, prot_open};
                csp_pkg::OFS_FAIL:     rdata_ff <= {30'h0, fail_ff, fden_ff};
                default:               rdata_ff <= 32'h0;
            endcase
        end
    end

    // Signature opens one change
    // Interrupts held off while the window is open, same edge as the window
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prot_ff  <= 3'h0;
            irq_mask <= 1'b0;
        end else if (wr_lo && reg_idx == csp_pkg::OFS_PROT
                     && avs_writedata[7:0] == csp_pkg::PROT_SIG) begin
            prot_ff  <= 3'(csp_pkg::PROT_WIN);
            irq_mask <= 1'b1;
        end else if (wr_lo && prot_open && (reg_idx == csp_pkg::OFS_CLK_SEL
                     || reg_idx == csp_pkg::OFS_PSC || reg_idx == csp_pkg::OFS_LOCK
                     || reg_idx == csp_pkg::OFS_FAIL)) begin
            prot_ff  <= 3'h0;
            irq_mask <= 1'b0;
        end else if (prot_open) begin
            prot_ff  <= prot_ff - 3'h1;
            irq_mask <= (prot_ff != 3'h1);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_ff <= 1'b0;
        end else if (fail_rise) begin
            lock_ff <= 1'b0;
        end else if (wr_lo && reg_idx == csp_pkg::OFS_LOCK && prot_open
                     && avs_writedata[0]) begin
            lock_ff <= 1'b1;
        end
    end

    // Detector enable is one-way until reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fden_ff <= 1'b0;
            fail_ff <= 1'b0;
        end else begin
            fail_ff <= ext_osc_fail;
            if (wr_lo && reg_idx == csp_pkg::OFS_FAIL && prot_open && avs_writedata[0])
                fden_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            xen_ff  <= 1'b0;
            men_ff  <= 1'b0;
            xcfg_ff <= '0;
            mcfg_ff <= '{src: csp_pkg::PLL_SRC_RC2M, factor: csp_pkg::PLL_FAC_MIN};
        end else begin
            if (fail_rise)
                xen_ff <= 1'b0;
            else if (wr_lo && reg_idx == csp_pkg::OFS_OSC_EN && !lock_ff) begin
                xen_ff <= avs_writedata[0];
                if (!(avs_writedata[1] && mcfg_ff.src == csp_pkg::PLL_SRC_EXTERNAL_CRYSTAL_OSCILLATOR
                      && xcfg_ff.type_sel == csp_pkg::XSEL_WATCH))
                    men_ff <= avs_writedata[1];
            end
            // Type field; low-power only in watch mode
            if (wr_lo && reg_idx == csp_pkg::OFS_EXTERNAL_CRYSTAL_OSCILLATOR_CFG && !xen_ff && !lock_ff) begin
                xcfg_ff.type_sel  <= avs_writedata[4:1];
                xcfg_ff.low_power <= avs_writedata[0]
                                     && avs_writedata[4:1] == csp_pkg::XSEL_WATCH;
            end
            // Factor 1..31, four inputs, no watch crystal
            if (wr_lo && reg_idx == csp_pkg::OFS_MUL_CFG && !men_ff && !lock_ff
                && avs_writedata[4:0] >= csp_pkg::PLL_FAC_MIN
                && !(avs_writedata[6:5] == csp_pkg::PLL_SRC_EXTERNAL_CRYSTAL_OSCILLATOR
                     && xcfg_ff.type_sel == csp_pkg::XSEL_WATCH))
                mcfg_ff <= avs_writedata[6:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            xst_ff  <= csp_pkg::XS_OFF;
            xcnt_ff <= 16'h0;
            xrdy_ff <= 1'b0;
        end else begin
            case (xst_ff)
                csp_pkg::XS_OFF: begin
                    xrdy_ff <= 1'b0;
                    xcnt_ff <= 16'h0;
                    if (xen_ff)
                        xst_ff <= csp_pkg::XS_START;
                end
                csp_pkg::XS_START: begin
                    if (!xen_ff)
                        xst_ff <= csp_pkg::XS_OFF;
                    else if (xcnt_ff == external_crystal_oscillator_delay(xcfg_ff.type_sel)) begin
                        if (external_crystal_oscillator_stable || xcfg_ff.type_sel == csp_pkg::XSEL_EXTCLK) begin
                            xst_ff  <= csp_pkg::XS_READY;
                            xrdy_ff <= 1'b1;
                        end
                    end else if (ext_ref_tick)
                        xcnt_ff <= xcnt_ff + 16'h1;
                end
                csp_pkg::XS_READY: begin
                    if (!xen_ff) begin
                        xst_ff  <= csp_pkg::XS_OFF;
                        xrdy_ff <= 1'b0;
                    end
                end
                default: xst_ff <= csp_pkg::XS_OFF;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mcnt_ff <= 8'h0;
            mrdy_ff <= 1'b0;
        end else if (!men_ff) begin
            mcnt_ff <= 8'h0;
            mrdy_ff <= 1'b0;
        end else if (mcnt_ff == csp_pkg::PLL_LOCK_CYC) begin
            mrdy_ff <= 1'b1;
        end else if (ext_ref_tick) begin
            mcnt_ff <= mcnt_ff + 8'h1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_ff <= csp_pkg::SEL_RC2M;
        end else if (fail_rise && sel_ff == csp_pkg::SEL_EXTERNAL_CRYSTAL_OSCILLATOR) begin
            sel_ff <= csp_pkg::SEL_RC2M;
        end else if (wr_lo && reg_idx == csp_pkg::OFS_CLK_SEL && prot_open
                     && !lock_ff && sel_ok) begin
            sel_ff <= avs_writedata[2:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_ff <= 1'b0;
        end else begin
            nmi_ff <= fail_rise;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            psc_ff <= '{a_log2: csp_pkg::PSA_RST, bc: csp_pkg::PSBC_RST};
        end else if (wr_lo && reg_idx == csp_pkg::OFS_PSC && prot_open && !lock_ff
                     && avs_writedata[5:2] <= csp_pkg::PSA_MAX
                     && avs_writedata[1:0] != 2'h3) begin
            psc_ff <= avs_writedata[5:0];
        end
    end

    // Stage A divides by 2^n up to 512
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pa_cnt_ff <= 11'h0;
        end else if (pa_tick) begin
            pa_cnt_ff <= 11'h0;
        end else begin
            pa_cnt_ff <= pa_cnt_ff + 11'h1;
        end
    end
    // New ratio applies to the running count; a count already past it wraps at once
    assign pa_tick = (pa_cnt_ff >= (11'h1 << psc_ff.a_log2) - 11'h1);

    // Stages B/C: 4x, 2x, 1x enables
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_cnt_ff <= 2'h0;
            per4x_ff  <= 1'b0;
            per2x_ff  <= 1'b0;
            cpu_ff    <= 1'b0;
        end else begin
            per4x_ff <= pa_tick;
            if (pa_tick) begin
                pc_cnt_ff <= (pc_cnt_ff + 2'h1) & ((2'h1 << psc_ff.bc) - 2'h1);
                per2x_ff  <= (psc_ff.bc == 2'h2) ? !pc_cnt_ff[0] : 1'b1;
                cpu_ff    <= (((pc_cnt_ff + 2'h1) & ((2'h1 << psc_ff.bc) - 2'h1)) == 2'h0);
            end else begin
                per2x_ff <= 1'b0;
                cpu_ff   <= 1'b0;
            end
        end
    end

    // Wait drops for the cycle after the request; read data already stands
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
        end
    end

    assign avs_readdata            = rdata_ff;
    assign ext_osc_enable          = xen_ff;
    assign ext_osc_type_select     = xcfg_ff.type_sel;
    assign watch_crystal_low_power = xcfg_ff.low_power;
    assign multiplier_enable       = men_ff;
    assign multiplier_input_select = mcfg_ff.src;
    assign multiplier_factor       = mcfg_ff.factor;
    assign sys_clk_select          = sel_ff;
    assign cpu_clk_en              = cpu_ff;
    assign per2x_clk_en            = per2x_ff;
    assign per4x_clk_en            = per4x_ff;
    assign nmi_pulse               = nmi_ff;

    reset_sel_a: assert property (@(posedge core_clk)
        $rose(arst_n) |-> sel_ff == csp_pkg::SEL_RC2M && psc_ff.bc == 2'h0)
        else $error("reset selection wrong");
    lock_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        lock_ff && !fail_rise |=> $stable(sel_ff) || sel_ff == csp_pkg::SEL_RC2M)
        else $error("locked selection changed");
    mul_ready_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(mrdy_ff) |-> men_ff && $past(mcnt_ff) == csp_pkg::PLL_LOCK_CYC)
        else $error("multiplier ready early");
    fail_nmi_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        fail_rise |=> nmi_pulse ##1 !nmi_pulse)
        else $error("no nmi after failure");
    fail_unlock_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        fail_rise |=> !lock_ff)
        else $error("lock kept after failure");
    xcfg_frozen_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        xen_ff && $past(xen_ff) |-> $stable(xcfg_ff))
        else $error("oscillator config changed");
    mcfg_frozen_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        men_ff && $past(men_ff) |-> $stable(mcfg_ff))
        else $error("multiplier config changed");
    sel_ready_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $changed(sel_ff) && sel_ff != csp_pkg::SEL_RC2M |-> $past(sel_ok))
        else $error("unready source selected");
endmodule

// ### shared/csp_pkg.sv
// Purpose: Constants and types for the system clock unit
// Assumes: Avalon-MM slave, 32-bit data, word registers at byte offsets
package csp_pkg;
    localparam logic [3:0] OFS_OSC_EN   = 4'h0;
    localparam logic [3:0] OFS_OSC_RDY  = 4'h1;
    localparam logic [3:0] OFS_EXTERNAL_CRYSTAL_OSCILLATOR_CFG = 4'h2;
    localparam logic [3:0] OFS_MUL_CFG  = 4'h3;
    localparam logic [3:0] OFS_CLK_SEL  = 4'h4;
    localparam logic [3:0] OFS_PSC      = 4'h5;
    localparam logic [3:0] OFS_LOCK     = 4'h6;
    localparam logic [3:0] OFS_PROT     = 4'h7;
    localparam logic [3:0] OFS_FAIL     = 4'h8;
    localparam logic [7:0] PROT_SIG     = 8'hD8;
    localparam int         PROT_WIN     = 4;
    localparam logic [3:0] XSEL_WATCH   = 4'h2;
    localparam logic [3:0] XSEL_EXTCLK  = 4'h0;
    localparam logic [3:0] XSEL_R0      = 4'h3;
    localparam logic [3:0] XSEL_R1      = 4'h4;
    localparam logic [3:0] XSEL_R2      = 4'h5;
    localparam logic [3:0] XSEL_R3      = 4'h6;
    localparam logic [15:0] XDLY_EXTCLK = 16'h0006;
    localparam logic [15:0] XDLY_WATCH  = 16'h4000;
    localparam logic [15:0] XDLY_XTAL   = 16'h0400;
    localparam logic [7:0] PLL_LOCK_CYC = 8'h40;
    localparam logic [4:0] PLL_FAC_MIN  = 5'h01;
    localparam logic [1:0] PLL_SRC_RC2M = 2'h0;
    localparam logic [1:0] PLL_SRC_R32M = 2'h1;
    localparam logic [1:0] PLL_SRC_EXTERNAL_CRYSTAL_OSCILLATOR = 2'h2;
    localparam logic [1:0] PLL_SRC_XCLK = 2'h3;
    localparam logic [2:0] SEL_RC2M     = 3'h0;
    localparam logic [2:0] SEL_R32M     = 3'h1;
    localparam logic [2:0] SEL_RC32K    = 3'h2;
    localparam logic [2:0] SEL_EXTERNAL_CRYSTAL_OSCILLATOR     = 3'h3;
    localparam logic [2:0] SEL_PLL      = 3'h4;
    localparam logic [3:0] PSA_RST      = 4'h0;
    localparam logic [3:0] PSA_MAX      = 4'h9;
    localparam logic [1:0] PSBC_RST     = 2'h0;

    typedef struct packed {
        logic [3:0] type_sel;
        logic       low_power;
    } csp_xcfg_t;

    typedef struct packed {
        logic [1:0] src;
        logic [4:0] factor;
    } csp_mcfg_t;

    typedef struct packed {
        logic [3:0] a_log2;
        logic [1:0] bc;
    } csp_psc_t;

    typedef enum { XS_OFF, XS_START, XS_READY } csp_xstate_t;
endpackage

// ### bench/csp_external_crystal_oscillator_model.sv
// Purpose: External clock generator or crystal beside the clock unit
// Assumes: One tick per reference period at a steady rate
// Notes: Ticks stand still while off or killed, so a failure is visible
`timescale 1ns/1ps
module csp_external_crystal_oscillator_model #(
    parameter int TICK_DIV   = 4,
    parameter int XTAL_START = 16
) (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       osc_on,
    input  wire logic [3:0] type_sel,
    input  wire logic       kill,
    output logic            ext_ref_tick,
    output logic            external_crystal_oscillator_stable,
    output logic            ext_osc_fail
);
    int   div_ff;
    int   run_ff;
    logic tick_ff;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_ff  <= 0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= (osc_on && !kill && div_ff < TICK_DIV - 1) ? div_ff + 1 : 0;
            tick_ff <= osc_on && !kill && (div_ff == TICK_DIV - 1);
        end
    end
    // Crystal start-up count
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_ff <= 0;
        end else begin
            run_ff <= (osc_on && !kill) ? run_ff + 32'(tick_ff) : 0;
        end
    end
    assign ext_ref_tick = tick_ff;
    assign external_crystal_oscillator_stable  = osc_on && !kill &&
                          (type_sel == csp_pkg::XSEL_EXTCLK || run_ff >= XTAL_START);
    assign ext_osc_fail = kill;
endmodule

// ### bench/csp_clock_unit_tb.sv
// Purpose: Self-checking bench for the system clock unit
// Assumes: Bus answers by waitrequest, sampled at the rising edge
// Notes: Row table first, then hand-written sequences
`timescale 1ns/1ps
module csp_clock_unit_tb;
    typedef struct packed {
        logic [3:0]  idx;
        logic [31:0] wd;
        logic        prot;
        logic [31:0] exp;
    } csp_row_t;
    logic        core_clk, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable, ext_osc_type_select;
    logic        ext_ref_tick, external_crystal_oscillator_stable, ext_osc_fail, osc_kill;
    logic        ext_osc_enable, watch_crystal_low_power, multiplier_enable;
    logic [1:0]  multiplier_input_select;
    logic [4:0]  multiplier_factor;
    logic [2:0]  sys_clk_select;
    logic        cpu_clk_en, per2x_clk_en, per4x_clk_en, irq_mask, nmi_pulse;
    int          error_cnt, cmp_count, tick_cnt, nmi_cnt, t0;
    int          c4_cnt, c2_cnt, cc_cnt;
    csp_row_t    rows [15];

    csp_clock_unit DUT (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_ref_tick(ext_ref_tick),
        .external_crystal_oscillator_stable(external_crystal_oscillator_stable), .ext_osc_fail(ext_osc_fail), .rc2m_ready_in(1'b1),
        .r32m_ready_in(1'b1), .rc32k_ready_in(1'b0), .ext_osc_enable(ext_osc_enable),
        .ext_osc_type_select(ext_osc_type_select),
        .watch_crystal_low_power(watch_crystal_low_power),
        .multiplier_enable(multiplier_enable),
        .multiplier_input_select(multiplier_input_select),
        .multiplier_factor(multiplier_factor), .sys_clk_select(sys_clk_select),
        .cpu_clk_en(cpu_clk_en), .per2x_clk_en(per2x_clk_en), .per4x_clk_en(per4x_clk_en),
        .irq_mask(irq_mask), .nmi_pulse(nmi_pulse));

    csp_external_crystal_oscillator_model u_external_crystal_oscillator (.core_clk(core_clk), .arst_n(arst_n), .osc_on(ext_osc_enable),
        .type_sel(ext_osc_type_select), .kill(osc_kill), .ext_ref_tick(ext_ref_tick),
        .external_crystal_oscillator_stable(external_crystal_oscillator_stable), .ext_osc_fail(ext_osc_fail));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Mid-cycle sampling keeps clear of edge races
    always @(negedge core_clk) begin
        tick_cnt += (ext_ref_tick === 1'b1);
        nmi_cnt  += (nmi_pulse === 1'b1);
        c4_cnt   += (per4x_clk_en === 1'b1);
        c2_cnt   += (per2x_clk_en === 1'b1);
        cc_cnt   += (cpu_clk_en === 1'b1);
    end

    task automatic wrap_up();
        if (error_cnt == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // Request held until waitrequest seen low
    task automatic bus_op(input logic wr, input logic [3:0] idx, input logic [31:0] d,
                          output logic [31:0] q);
        int n;
        n = 0;
        avs_address   <= {idx, 2'b00};
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 100) begin
                error_cnt++;
                wrap_up();
            end
            @(posedge core_clk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic bus_wr(input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus_op(1'b1, idx, d, q);
    endtask

    task automatic bus_rd(input logic [3:0] idx, output logic [31:0] q);
        bus_op(1'b0, idx, 32'h0, q);
    endtask

    task automatic prot_wr(input logic [3:0] idx, input logic [31:0] d);
        bus_wr(csp_pkg::OFS_PROT, {24'h0, csp_pkg::PROT_SIG});
        bus_wr(idx, d);
    endtask

    task automatic poll_rdy(input int b, output int dn);
        int n;
        n  = 0;
        rd = 32'h0;
        while (rd[b] !== 1'b1 && n < 400) begin
            bus_rd(csp_pkg::OFS_OSC_RDY, rd);
            n++;
        end
        dn = tick_cnt - t0;
    endtask

    // Pulses per window; a whole number of periods makes the phase irrelevant
    task automatic clk_cnt(input int span, input int e4, input int e2, input int ec);
        c4_cnt = 0;
        c2_cnt = 0;
        cc_cnt = 0;
        repeat (span) @(posedge core_clk);
        chk("per4x pulses", c4_cnt, e4);
        chk("per2x pulses", c2_cnt, e2);
        chk("cpu pulses", cc_cnt, ec);
    endtask

    task automatic do_reset(input int n);
        arst_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        chk("sys_clk_select", sys_clk_select, csp_pkg::SEL_RC2M);
        chk("multiplier_enable", multiplier_enable, 1'b0);
        bus_rd(csp_pkg::OFS_PSC, rd);
        chk("prescaler reset", rd, 32'h0);
        clk_cnt(8, 8, 8, 8);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        int dn;
        arst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        osc_kill = 1'b0;
        rows = '{'{4'h4, 32'h1, 1'b0, 32'h0},
                 '{4'h4, 32'h1, 1'b1, 32'h1},
                 '{4'h4, 32'h2, 1'b1, 32'h1},
                 '{4'h5, 32'h25, 1'b1, 32'h25},
                 '{4'h5, 32'h00, 1'b0, 32'h25},
                 '{4'h4, 32'h0, 1'b1, 32'h0},
                 '{4'h2, 32'h0, 1'b0, 32'h0},
                 '{4'h2, 32'h4, 1'b0, 32'h4},
                 '{4'h2, 32'h6, 1'b0, 32'h6},
                 '{4'h2, 32'h8, 1'b0, 32'h8},
                 '{4'h2, 32'hA, 1'b0, 32'hA},
                 '{4'h2, 32'hC, 1'b0, 32'hC},
                 '{4'h3, 32'h01, 1'b0, 32'h01},
                 '{4'h3, 32'h22, 1'b0, 32'h22},
                 '{4'h3, 32'h7F, 1'b0, 32'h7F}};
        @(posedge core_clk);
        do_reset(4);
        foreach (rows[i]) begin
            if (rows[i].prot) begin
                bus_wr(csp_pkg::OFS_PROT, {24'h0, csp_pkg::PROT_SIG});
                chk("irq_mask", irq_mask, 1'b1);
            end
            bus_wr(rows[i].idx, rows[i].wd);
            bus_rd(rows[i].idx, rd);
            chk("row readback", rd, rows[i].exp);
        end
        // Stage A by 512, B/C by 2: per4x and per2x every 512, cpu every 1024
        clk_cnt(2048, 4, 4, 2);
        bus_wr(csp_pkg::OFS_EXTERNAL_CRYSTAL_OSCILLATOR_CFG, 32'({csp_pkg::XSEL_EXTCLK, 1'b1}));
        chk("low power outside watch", watch_crystal_low_power, 1'b0);
        t0 = tick_cnt;
        bus_wr(csp_pkg::OFS_OSC_EN, 32'h1);
        poll_rdy(0, dn);
        chk("external_crystal_oscillator start ticks", 32'(dn >= 6 && dn <= 9), 32'h1);
        bus_wr(csp_pkg::OFS_EXTERNAL_CRYSTAL_OSCILLATOR_CFG, 32'({csp_pkg::XSEL_R0, 1'b0}));
        chk("type while enabled", ext_osc_type_select, csp_pkg::XSEL_EXTCLK);
        prot_wr(csp_pkg::OFS_CLK_SEL, 32'(csp_pkg::SEL_EXTERNAL_CRYSTAL_OSCILLATOR));
        chk("select external_crystal_oscillator", sys_clk_select, csp_pkg::SEL_EXTERNAL_CRYSTAL_OSCILLATOR);
        t0 = tick_cnt;
        bus_wr(csp_pkg::OFS_OSC_EN, 32'h3);
        poll_rdy(1, dn);
        chk("pll lock ticks", 32'(dn >= 64), 32'h1);
        bus_wr(csp_pkg::OFS_MUL_CFG, 32'h62);
        chk("factor while enabled", multiplier_factor, 5'h1F);
        bus_wr(csp_pkg::OFS_OSC_EN, 32'h1);
        prot_wr(csp_pkg::OFS_FAIL, 32'h1);
        prot_wr(csp_pkg::OFS_LOCK, 32'h1);
        prot_wr(csp_pkg::OFS_CLK_SEL, 32'(csp_pkg::SEL_RC2M));
        chk("select when locked", sys_clk_select, csp_pkg::SEL_EXTERNAL_CRYSTAL_OSCILLATOR);
        prot_wr(csp_pkg::OFS_PSC, 32'h0);
        bus_rd(csp_pkg::OFS_PSC, rd);
        chk("prescaler when locked", rd, 32'h25);
        bus_wr(csp_pkg::OFS_OSC_EN, 32'h0);
        chk("enable when locked", ext_osc_enable, 1'b1);
        osc_kill <= 1'b1;
        dn = 0;
        while (nmi_cnt == 0 && dn < 200) begin
            @(posedge core_clk);
            dn++;
        end
        chk("nmi count", nmi_cnt, 32'h1);
        chk("fallback select", sys_clk_select, csp_pkg::SEL_RC2M);
        osc_kill <= 1'b0;
        prot_wr(csp_pkg::OFS_CLK_SEL, 32'(csp_pkg::SEL_R32M));
        chk("select after failure", sys_clk_select, csp_pkg::SEL_R32M);
        bus_wr(csp_pkg::OFS_OSC_EN, 32'h0);
        bus_wr(csp_pkg::OFS_EXTERNAL_CRYSTAL_OSCILLATOR_CFG, 32'({csp_pkg::XSEL_WATCH, 1'b1}));
        chk("low power in watch", watch_crystal_low_power, 1'b1);
        bus_wr(csp_pkg::OFS_MUL_CFG, 32'({csp_pkg::PLL_SRC_EXTERNAL_CRYSTAL_OSCILLATOR, 5'h04}));
        chk("watch crystal refused", multiplier_input_select, csp_pkg::PLL_SRC_XCLK);
        prot_wr(csp_pkg::OFS_CLK_SEL, 32'(csp_pkg::SEL_RC2M));
        bus_wr(csp_pkg::OFS_PSC, 32'h0);
        bus_rd(csp_pkg::OFS_PSC, rd);
        chk("second change", rd, 32'h25);
        chk("first change", sys_clk_select, csp_pkg::SEL_RC2M);
        do_reset(2);
        wrap_up();
    end
endmodule
